// ### rtl/typeb_request_command_decoder.sv
// frame byte decoder: layer-3 commands, block types and instruction codes
`timescale 1ns/1ps
module typeb_request_command_decoder (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic rx_crc_ok,
  input wire logic [7:0] stored_afi,
  input wire logic tunnel_mode,
  output logic cmd_valid,
  output logic [3:0] cmd_kind,
  output logic cmd_to_host,
  output logic cmd_chained,
  output logic [7:0] cmd_ins,
  output logic [1:0] card_state,
  output logic [7:0] atqb_proto2
);
  typedef struct packed {
    cmd_dec_pkg::card_state_t st;
    logic [8:0] cnt;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic oversize;
    logic out_valid;
    cmd_dec_pkg::cmd_kind_t out_kind;
    logic out_host;
    logic out_chain;
    logic [7:0] out_ins;
  } dec_state_t;

  dec_state_t s_reg;
  dec_state_t s_next;
  logic afi_hit;
  logic is_wake;
  logic [7:0] pcb_type;
  logic [8:0] byte_idx;

  // family filter on the second byte of a request frame
  afi_match u_afi (
    .req_afi(s_reg.b1),
    .stored_afi(stored_afi),
    .hit(afi_hit)
  );

  // parameter bit 3 picks wake-up; bits 7-5 and slot bits never read
  assign is_wake = s_reg.b2[cmd_dec_pkg::PARAM_WAKE_BIT];
  assign pcb_type = s_reg.b0 & cmd_dec_pkg::PCB_BLOCK_MASK;
  // start of frame may arrive with the first byte, so the index restarts at once
  assign byte_idx = rx_sof ? cmd_dec_pkg::CNT_RESET : s_reg.cnt;

  // byte capture during a frame, decode at end of frame
  always_comb begin
    s_next = s_reg;
    s_next.out_valid = 1'b0;
    if (rx_sof) begin
      s_next.cnt = cmd_dec_pkg::CNT_RESET;
      s_next.oversize = 1'b0;
    end
    if (rx_valid) begin
      // bytes beyond the limit spoil the frame
      if (byte_idx >= cmd_dec_pkg::MAX_FRAME_BYTES) begin
        s_next.oversize = 1'b1;
      end else begin
        s_next.cnt = byte_idx + 9'h001;
      end
      case (byte_idx)
        9'h000: s_next.b0 = rx_byte;
        9'h001: s_next.b1 = rx_byte;
        9'h002: s_next.b2 = rx_byte;
        9'h003: s_next.b3 = rx_byte;
        default: s_next.b3 = s_reg.b3;
      endcase
    end
    // a frame with a bad crc is dropped silently, as the link expects
    if (rx_eof && rx_crc_ok) begin
      s_next.out_kind = cmd_dec_pkg::CMD_NONE;
      s_next.out_host = 1'b0;
      s_next.out_chain = 1'b0;
      s_next.out_ins = cmd_dec_pkg::BYTE_RESET;
      if (s_reg.oversize) begin
        s_next.out_kind = cmd_dec_pkg::CMD_OVERSIZE;
      end else if (s_reg.st != cmd_dec_pkg::ST_ACTIVE) begin
        case (s_reg.b0)
          cmd_dec_pkg::CODE_REQ: begin
            // request needs IDLE or READY, wake-up works from IDLE, READY or HALT
            if (afi_hit && (s_reg.st != cmd_dec_pkg::ST_HALT || is_wake)) begin
              s_next.out_kind = cmd_dec_pkg::CMD_ATQB;
              s_next.st = cmd_dec_pkg::ST_READY;
            end
          end
          cmd_dec_pkg::CODE_ATTRIB: begin
            if (s_reg.st == cmd_dec_pkg::ST_READY) begin
              s_next.out_kind = cmd_dec_pkg::CMD_ATTRIB;
              s_next.st = cmd_dec_pkg::ST_ACTIVE;
            end
          end
          cmd_dec_pkg::CODE_HALT: begin
            if (s_reg.st == cmd_dec_pkg::ST_READY) begin
              s_next.out_kind = cmd_dec_pkg::CMD_HALT;
              s_next.st = cmd_dec_pkg::ST_HALT;
            end
          end
          default: s_next.out_kind = cmd_dec_pkg::CMD_NONE;
        endcase
      end else begin
        // block types in the active state
        case (pcb_type)
          cmd_dec_pkg::PCB_IBLOCK: begin
            s_next.out_chain = s_reg.b0[cmd_dec_pkg::PCB_CHAIN_BIT];
            s_next.out_ins = s_reg.b2;
            case (s_reg.b2)
              cmd_dec_pkg::INS_SELECT: s_next.out_kind = cmd_dec_pkg::CMD_SELECT;
              cmd_dec_pkg::INS_READ: begin
                s_next.out_kind = cmd_dec_pkg::CMD_READ;
                s_next.out_host = tunnel_mode;
              end
              cmd_dec_pkg::INS_WRITE: begin
                s_next.out_kind = cmd_dec_pkg::CMD_WRITE;
                s_next.out_host = tunnel_mode;
              end
              cmd_dec_pkg::INS_VERIFY: s_next.out_kind = cmd_dec_pkg::CMD_VERIFY;
              default: s_next.out_kind = cmd_dec_pkg::CMD_UNKNOWN;
            endcase
          end
          cmd_dec_pkg::PCB_RBLOCK: begin
            if (s_reg.b0[cmd_dec_pkg::PCB_NAK_BIT]) begin
              s_next.out_kind = cmd_dec_pkg::CMD_NAK;
            end else begin
              s_next.out_kind = cmd_dec_pkg::CMD_ACK;
            end
          end
          cmd_dec_pkg::PCB_SBLOCK: begin
            if (s_reg.b0 == cmd_dec_pkg::PCB_S_DESEL) begin
              s_next.out_kind = cmd_dec_pkg::CMD_DESEL;
              s_next.st = cmd_dec_pkg::ST_HALT;
            end else if (s_reg.b0 == cmd_dec_pkg::PCB_S_WTX) begin
              s_next.out_kind = cmd_dec_pkg::CMD_WTX;
            end else begin
              s_next.out_kind = cmd_dec_pkg::CMD_UNKNOWN;
            end
          end
          default: s_next.out_kind = cmd_dec_pkg::CMD_UNKNOWN;
        endcase
      end
      s_next.out_valid = (s_next.out_kind != cmd_dec_pkg::CMD_NONE);
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmd_valid = s_reg.out_valid;
  assign cmd_kind = s_reg.out_kind;
  assign cmd_to_host = s_reg.out_host;
  assign cmd_chained = s_reg.out_chain;
  assign cmd_ins = s_reg.out_ins;
  assign card_state = s_reg.st;
  // frame size code in upper nibble
  assign atqb_proto2 = {cmd_dec_pkg::FSCI_CODE, cmd_dec_pkg::PROTO_TYPE};
endmodule

// ### rtl/cmd_dec_pkg.sv
// constants, encodings and states for the proximity command decoder
package cmd_dec_pkg;
  localparam logic [7:0] CODE_REQ = 8'h05;
  localparam logic [7:0] CODE_ATTRIB = 8'h1d;
  localparam logic [7:0] CODE_HALT = 8'h50;
  localparam logic [7:0] INS_SELECT = 8'ha4;
  localparam logic [7:0] INS_READ = 8'hb0;
  localparam logic [7:0] INS_WRITE = 8'hd6;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam int PARAM_WAKE_BIT = 3;
  localparam logic [8:0] MAX_FRAME_BYTES = 9'h100;
  localparam logic [3:0] FSCI_CODE = 4'h8;
  localparam logic [3:0] PROTO_TYPE = 4'h1;
  localparam logic [7:0] PCB_BLOCK_MASK = 8'hc0;
  localparam logic [7:0] PCB_IBLOCK = 8'h00;
  localparam logic [7:0] PCB_RBLOCK = 8'h80;
  localparam logic [7:0] PCB_SBLOCK = 8'hc0;
  localparam int PCB_CHAIN_BIT = 4;
  localparam int PCB_NAK_BIT = 4;
  localparam logic [7:0] PCB_S_DESEL = 8'hc2;
  localparam logic [7:0] PCB_S_WTX = 8'hf2;
  localparam logic [8:0] CNT_RESET = 9'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READY = 2'b01,
    ST_ACTIVE = 2'b11,
    ST_HALT = 2'b10
  } card_state_t;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_ATQB = 4'h1, CMD_ATTRIB = 4'h2, CMD_HALT = 4'h3,
    CMD_SELECT = 4'h4, CMD_READ = 4'h5, CMD_WRITE = 4'h6, CMD_VERIFY = 4'h7,
    CMD_UNKNOWN = 4'h8, CMD_ACK = 4'h9, CMD_NAK = 4'ha, CMD_DESEL = 4'hb,
    CMD_WTX = 4'hc, CMD_OVERSIZE = 4'hd
  } cmd_kind_t;
endpackage

// ### rtl/afi_match.sv
// family identifier filter for the request/wake-up command
`timescale 1ns/1ps
module afi_match (
  input wire logic [7:0] req_afi,
  input wire logic [7:0] stored_afi,
  output logic hit
);
  // four cases by which nibbles of the requested family are zero
  always_comb begin
    if (req_afi == 8'h00) begin
      hit = 1'b1;
    end else if (req_afi[3:0] == 4'h0) begin
      hit = (req_afi[7:4] == stored_afi[7:4]);
    end else if (req_afi[7:4] == 4'h0) begin
      hit = (req_afi[3:0] == stored_afi[3:0]);
    end else begin
      hit = (req_afi == stored_afi);
    end
  end
endmodule

// ### verif/cmd_dec_monitor.sv
// port assertions for the command decoder
`timescale 1ns/1ps
module cmd_dec_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rx_eof,
  input wire logic rx_crc_ok,
  input wire logic tunnel_mode,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_kind,
  input wire logic cmd_to_host,
  input wire logic [1:0] card_state,
  input wire logic [7:0] atqb_proto2
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // answers and state moves, checked in the pulse cycle
  property p_fsize; atqb_proto2[7:4] == 4'h8; endproperty
  a_fsize: assert property (p_fsize) else $error("frame size code");
  property p_crc; rx_eof && !rx_crc_ok |=> !cmd_valid; endproperty
  a_crc: assert property (p_crc) else $error("bad crc answered");
  property p_late; cmd_valid |-> $past(rx_eof) && $past(rx_crc_ok); endproperty
  a_late: assert property (p_late) else $error("pulse without eof");
  property p_halt; cmd_valid && cmd_kind == 4'h3 |-> card_state == 2'b10; endproperty
  a_halt: assert property (p_halt) else $error("halt state");
  property p_ready; cmd_valid && cmd_kind == 4'h1 |-> card_state == 2'b01; endproperty
  a_ready: assert property (p_ready) else $error("ready state");
  property p_wake; card_state == 2'b10 ##1 card_state == 2'b01 |-> cmd_valid; endproperty
  a_wake: assert property (p_wake) else $error("silent wake");
  property p_host; cmd_valid && cmd_kind inside {4'h5, 4'h6} |-> cmd_to_host == tunnel_mode;
  endproperty
  a_host: assert property (p_host) else $error("host target");
  property p_desel; cmd_valid && cmd_kind == 4'hb |-> card_state == 2'b10; endproperty
  a_desel: assert property (p_desel) else $error("deselect state");
  c_wake: cover property (p_wake);
  c_desel: cover property (cmd_valid && cmd_kind == 4'hb);
  c_crc: cover property (rx_eof && !rx_crc_ok);
endmodule
bind typeb_request_command_decoder cmd_dec_monitor u_cmd_dec_monitor (.*);

// ### verif/reader_model.sv
// reader side: hands frame bytes to the decoder
`timescale 1ns/1ps
module reader_model (
  input wire logic mclk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_crc_ok
);
  initial {rx_valid, rx_byte, rx_sof, rx_eof, rx_crc_ok} = '0;
  // code byte first, no identifier or address prefix
  task automatic send(input logic [7:0] b[$], input logic ok);
    foreach (b[i]) begin
      @(posedge mclk);
      {rx_valid, rx_sof, rx_byte} <= {1'b1, i == 0, b[i]};
    end
    @(posedge mclk);
    // released byte lane shows the inverse so stale data never matches
    {rx_valid, rx_sof, rx_eof, rx_crc_ok, rx_byte} <= {3'b001, ok, ~b[b.size()-1]};
    @(posedge mclk);
    {rx_eof, rx_crc_ok} <= 2'b00;
  endtask
endmodule

// ### verif/typeb_request_command_decoder_tb_top.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
module typeb_request_command_decoder_tb_top;
  logic mclk = 0, rst = 1, tunnel_mode = 0, hit;
  logic rx_valid, rx_sof, rx_eof, rx_crc_ok, cmd_valid, cmd_to_host, cmd_chained;
  logic [7:0] rx_byte, stored_afi = 0, cmd_ins, atqb_proto2, r, s, big[$];
  logic [7:0] ins_tab[5] = '{8'ha4, 8'hb0, 8'hd6, 8'h20, 8'h55};
  logic [3:0] cmd_kind;
  logic [1:0] card_state;
  logic [4:0] exp_q[$];
  int num_errors = 0, samples_checked = 0, k;
  initial forever #25 mclk = ~mclk;
  reader_model u_reader_model (.*);
  typeb_request_command_decoder u_typeb_request_command_decoder (.*);
  task check(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // note the expected answer, send, then settle past the pulse
  task frame(input logic [7:0] b[$], input logic ok, h, input logic [4:0] e);
    if (h) exp_q.push_back(e);
    u_reader_model.send(b, ok);
    @(posedge mclk);
    @(negedge mclk);
  endtask
  // oldest note against every pulse; an unnoted pulse is a refusal missed
  always @(negedge mclk) if (cmd_valid === 1'b1) begin
    if (exp_q.size() == 0) check("spurious", 1, 0);
    else check("kind", {cmd_to_host, cmd_kind}, exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    test_done;
  end
  initial begin
    void'($urandom(94293));
    repeat (3) @(posedge mclk);
    rst <= 0;
    @(negedge mclk);
    check("proto", atqb_proto2, 8'h81);
    // family filter, random slot and spare bits
    repeat (40) begin
      s = 8'($urandom);
      r = s;
      k = $urandom % 4;
      if (k == 1) r[3:0] = 0;
      if (k == 2) r[7:4] = 0;
      if (k == 3) r = 0;
      if ($urandom % 3 == 0) r ^= 8'h10;
      hit = r == 0 || r == s || (r[3:0] == 0 && r[7:4] == s[7:4]) ||
        (r[7:4] == 0 && r[3:0] == s[3:0]);
      stored_afi <= s;
      frame('{8'h05, r, 8'h08 | 8'($urandom)}, 1, hit, 5'h01);
    end
    frame('{8'h05, 8'h00, 8'h00}, 1, 1, 5'h01);
    frame('{8'h50, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1, 5'h03);
    frame('{8'h05, 8'h00, 8'h00}, 1, 0, 0);
    frame('{8'h05, 8'h00, 8'h08}, 0, 0, 0);
    frame('{8'h05, 8'h00, 8'h08}, 1, 1, 5'h01);
    frame('{8'h1d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h01, 8'h00}, 1, 1, 5'h02);
    check("active", card_state, 2'b11);
    // each instruction with tunnel off and on
    for (k = 0; k < 10; k++) begin
      tunnel_mode <= k[0];
      frame('{8'h02, 8'h00, ins_tab[k/2]}, 1, 1, {k[0] && k/2 inside {1, 2}, 4'(k/2 + 4)});
      check("ins", cmd_ins, ins_tab[k/2]);
    end
    frame('{8'h12, 8'h00, 8'hb0}, 1, 1, 5'h15);
    check("chain", cmd_chained, 1);
    frame('{8'ha2}, 1, 1, 5'h09);
    frame('{8'hb2}, 1, 1, 5'h0a);
    frame('{8'hf2, 8'h01}, 1, 1, 5'h0c);
    repeat (257) big.push_back(8'h02);
    frame(big, 1, 1, 5'h0d);
    frame('{8'hc2}, 1, 1, 5'h0b);
    check("left", exp_q.size(), 0);
    test_done;
  end
endmodule
